// ---- hdl/train_presence_alarm_scanner.sv ----
// Two-track presence detection, axle counting and alarm scanning.
// Assumes AHB-Lite master, asynchronous pins, alarm contacts high when closed.
// Function
// - Transducer pulse starts alarm scanning
// - Scanning continues while pulses under nine seconds apart
// - Nine-second pulse gap ends the train
// - Four or more axles means valid train
// - Two or three axles means test train in transducer mode
// - One axle gives no record in transducer mode
// - Closed approach circuit starts and holds scanning
// - Approach circuit opening ends train
// - Continuous mode keeps track always active
// - Continuous mode reports alarms immediately
// - Four alarm inputs, each typed separately
// - Type selects one of ten or unused
// - Train modes accept only four load types
// - Continuous mode accepts all ten types
// - Two independent tracks, own activation each
// - Notify arrival and departure
// - Immediate alarm message during passage
// - Buffer train data, hand over afterwards
// - Open contact while scanning raises alarm
// - Dragger rearm needs reclose and three axles in transducer mode, reclose only otherwise
// - Input open before arrival is stuck, suppressed, in train modes only
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module train_presence_alarm_scanner #(
    parameter int unsigned END_GAP = presence_pkg::END_GAP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire presence_pkg::track_pins_s [1:0] pins,
    output logic [1:0] scanning
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic type_allowed(input logic [1:0] mode, input logic [3:0] t);
        logic ok;
        ok = 1'b0;
        if (mode == presence_pkg::MODE_CONTINUOUS) begin
            ok = (t != presence_pkg::ALM_NOT_USED) && (t <= presence_pkg::ALM_POWER_OFF);
        end else if (mode != presence_pkg::MODE_OFF) begin
            ok = (t >= presence_pkg::ALM_DRAGGING) && (t <= presence_pkg::ALM_SHIFTED_LOAD);
        end
        return ok;
    endfunction

    function automatic logic [3:0] alarm_bits(input presence_pkg::track_pins_s p);
        return {p.alarm_input_fourth, p.alarm_input_third, p.alarm_input_second,
                p.alarm_input_first};
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    presence_pkg::track_pins_s [1:0] sync_a;
    presence_pkg::track_pins_s [1:0] sync_b;
    presence_pkg::track_pins_s [1:0] sync_c;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [31:0] cfg [2];
    logic [15:0] events;
    presence_pkg::record_s rec [2];
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg[0] <= presence_pkg::CFG_RESET;
            cfg[1] <= presence_pkg::CFG_RESET;
        end else if (wr_pend) begin
            if (addr_q == presence_pkg::CFG0_OFF) begin
                cfg[0] <= hwdata;
            end
            if (addr_q == presence_pkg::CFG1_OFF) begin
                cfg[1] <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-track scanning
    // ------------------------------------------------------------
    logic [1:0] active;
    logic [1:0] arrive;
    logic [1:0] depart;
    logic [1:0] alarm_ev;
    logic [15:0] axles [2];
    logic [presence_pkg::GAP_W-1:0] gap [2];
    logic [3:0] stuck [2];
    logic [3:0] seen [2];
    logic [3:0] armed [2];
    logic [15:0] rearm_axle [2];
    logic [1:0] mode [2];
    logic [3:0] alm_open [2];
    logic [1:0] pulse;

    assign scanning = active;

    always_comb begin
        for (int t = 0; t < 2; t++) begin
            mode[t] = cfg[t][presence_pkg::MODE_LSB +: 2];
            alm_open[t] = ~alarm_bits(sync_c[t]);
            pulse[t] = sync_b[t].transducer && !sync_c[t].transducer;
        end
    end

    always_comb begin
        for (int t = 0; t < 2; t++) begin
            arrive[t] = 1'b0;
            depart[t] = 1'b0;
            unique case (mode[t])
                presence_pkg::MODE_TRANSDUCER: begin
                    arrive[t] = !active[t] && pulse[t];
                    depart[t] = active[t] && !pulse[t] && (gap[t] >= END_GAP);
                end
                presence_pkg::MODE_APPROACH: begin
                    arrive[t] = !active[t] && sync_c[t].approach_circuit_input;
                    depart[t] = active[t] && !sync_c[t].approach_circuit_input;
                end
                presence_pkg::MODE_CONTINUOUS: begin
                    arrive[t] = !active[t];
                end
                presence_pkg::MODE_OFF: begin
                    depart[t] = active[t];
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active <= 2'b00;
            alarm_ev <= 2'b00;
            for (int t = 0; t < 2; t++) begin
                axles[t] <= 16'h0000;
                gap[t] <= '0;
                stuck[t] <= 4'h0;
                seen[t] <= 4'h0;
                armed[t] <= 4'h0;
                rearm_axle[t] <= 16'h0000;
            end
        end else begin
            for (int t = 0; t < 2; t++) begin
                alarm_ev[t] <= 1'b0;
                if (arrive[t]) begin
                    active[t] <= 1'b1;
                    axles[t] <= {15'h0000, pulse[t]};
                    gap[t] <= '0;
                    seen[t] <= 4'h0;
                    stuck[t] <= (mode[t] == presence_pkg::MODE_CONTINUOUS) ? 4'h0 : alm_open[t];
                    armed[t] <= (mode[t] == presence_pkg::MODE_CONTINUOUS) ? 4'hF : ~alm_open[t];
                end else if (depart[t]) begin
                    active[t] <= 1'b0;
                end else if (active[t]) begin
                    gap[t] <= pulse[t] ? '0 : gap[t] + 1'b1;
                    if (pulse[t]) begin
                        axles[t] <= axles[t] + 16'h0001;
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (alm_open[t][i] && armed[t][i] && !stuck[t][i] &&
                            type_allowed(mode[t], cfg[t][presence_pkg::TYPE_LSB + 4*i +: 4])) begin
                            alarm_ev[t] <= 1'b1;
                            seen[t][i] <= 1'b1;
                            armed[t][i] <= 1'b0;
                            rearm_axle[t] <= axles[t];
                        end else if (!alm_open[t][i] && !armed[t][i] && !stuck[t][i]) begin
                            if (cfg[t][presence_pkg::TYPE_LSB + 4*i +: 4] == presence_pkg::ALM_DRAGGING
                                && mode[t] == presence_pkg::MODE_TRANSDUCER) begin
                                armed[t][i] <= (axles[t] - rearm_axle[t]) >=
                                    16'(presence_pkg::REARM_AXLES);
                            end else begin
                                armed[t][i] <= 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Records and events
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rec[0] <= '0;
            rec[1] <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (depart[t] && mode[t] != presence_pkg::MODE_CONTINUOUS &&
                    (axles[t] >= 16'(presence_pkg::TEST_AXLES) ||
                     mode[t] == presence_pkg::MODE_APPROACH)) begin
                    // Single axle in transducer mode is noise: the last record stays as it was
                    if (axles[t] >= 16'(presence_pkg::VALID_AXLES) ||
                        mode[t] == presence_pkg::MODE_APPROACH) begin
                        rec[t].cls <= presence_pkg::CLASS_VALID;
                    end else begin
                        rec[t].cls <= presence_pkg::CLASS_TEST;
                    end
                    rec[t].axles <= axles[t];
                    rec[t].alarm_seen <= seen[t];
                    rec[t].stuck <= stuck[t];
                end
            end
        end
    end

    // Sticky event bits: set wins over write-one-to-clear
    logic [15:0] ev_set;
    always_comb begin
        ev_set = 16'h0000;
        for (int t = 0; t < 2; t++) begin
            ev_set[t*presence_pkg::EV_TRACK_STRIDE + presence_pkg::EV_ARRIVE] = arrive[t];
            ev_set[t*presence_pkg::EV_TRACK_STRIDE + presence_pkg::EV_DEPART] = depart[t];
            ev_set[t*presence_pkg::EV_TRACK_STRIDE + presence_pkg::EV_ALARM] = alarm_ev[t];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            events <= 16'h0000;
        end else if (wr_pend && addr_q == presence_pkg::EVENT_OFF) begin
            events <= (events & ~hwdata[15:0]) | ev_set;
        end else begin
            events <= events | ev_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            unique case (haddr[7:0])
                presence_pkg::CFG0_OFF: hrdata <= cfg[0];
                presence_pkg::CFG1_OFF: hrdata <= cfg[1];
                presence_pkg::STAT0_OFF: hrdata <= {seen[0], stuck[0], 7'h00, active[0], axles[0]};
                presence_pkg::STAT1_OFF: hrdata <= {seen[1], stuck[1], 7'h00, active[1], axles[1]};
                presence_pkg::EVENT_OFF: hrdata <= {16'h0000, events};
                presence_pkg::REC0_OFF: hrdata <= {6'h00, rec[0]};
                presence_pkg::REC1_OFF: hrdata <= {6'h00, rec[1]};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_arrive_transducer;
        @(posedge hclk) disable iff (!hresetn)
        (mode[0] == presence_pkg::MODE_TRANSDUCER && arrive[0]) |=> active[0];
    endproperty
    a_arrive_transducer: assert property (p_arrive_transducer) else $error("no scan start");

    property p_gap_end;
        @(posedge hclk) disable iff (!hresetn)
        (mode[0] == presence_pkg::MODE_TRANSDUCER && active[0] && !pulse[0] && gap[0] >= END_GAP)
        |=> !active[0];
    endproperty
    a_gap_end: assert property (p_gap_end) else $error("train did not end");

    property p_pulse_keeps;
        @(posedge hclk) disable iff (!hresetn)
        (mode[0] == presence_pkg::MODE_TRANSDUCER && active[0] && pulse[0]) |=> active[0];
    endproperty
    a_pulse_keeps: assert property (p_pulse_keeps) else $error("scan dropped on pulse");

    property p_valid;
        @(posedge hclk) disable iff (!hresetn)
        (depart[0] && mode[0] == presence_pkg::MODE_TRANSDUCER && axles[0] >= 16'h0004)
        |=> rec[0].cls == presence_pkg::CLASS_VALID;
    endproperty
    a_valid: assert property (p_valid) else $error("valid class wrong");

    property p_test;
        @(posedge hclk) disable iff (!hresetn)
        (depart[0] && mode[0] == presence_pkg::MODE_TRANSDUCER && axles[0] inside {2, 3})
        |=> rec[0].cls == presence_pkg::CLASS_TEST;
    endproperty
    a_test: assert property (p_test) else $error("test class wrong");

    property p_approach_end;
        @(posedge hclk) disable iff (!hresetn)
        (mode[1] == presence_pkg::MODE_APPROACH && active[1] && !sync_c[1].approach_circuit_input)
        |=> !active[1] && events[presence_pkg::EV_TRACK_STRIDE + presence_pkg::EV_DEPART];
    endproperty
    a_approach_end: assert property (p_approach_end) else $error("approach end missed");

    property p_continuous;
        @(posedge hclk) disable iff (!hresetn)
        (mode[1] == presence_pkg::MODE_CONTINUOUS) ##1 (mode[1] == presence_pkg::MODE_CONTINUOUS)
        |-> active[1];
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous track idle");

    // Only stuck inputs open: nothing may be reported
    property p_stuck_silent;
        @(posedge hclk) disable iff (!hresetn)
        (active[0] && stuck[0] != 4'h0 && (alm_open[0] & ~stuck[0]) == 4'h0) |=> !alarm_ev[0];
    endproperty
    a_stuck_silent: assert property (p_stuck_silent) else $error("stuck input alarmed");

    property p_discard;
        @(posedge hclk) disable iff (!hresetn)
        (depart[0] && mode[0] == presence_pkg::MODE_TRANSDUCER && axles[0] == 16'h0001)
        |=> $stable(rec[0]);
    endproperty
    a_discard: assert property (p_discard) else $error("single axle recorded");

    property p_scan_only_active;
        @(posedge hclk) disable iff (!hresetn)
        !active[0] |=> !alarm_ev[0];
    endproperty
    a_scan_only_active: assert property (p_scan_only_active) else $error("alarm while idle");

    property p_approach_start;
        @(posedge hclk) disable iff (!hresetn)
        (mode[1] == presence_pkg::MODE_APPROACH && !active[1] && sync_c[1].approach_circuit_input)
        |=> active[1];
    endproperty
    a_approach_start: assert property (p_approach_start) else $error("approach start missed");

    c_valid_train: cover property (@(posedge hclk) depart[0] && axles[0] >= 16'h0004);
    c_test_train: cover property (@(posedge hclk) depart[0] && axles[0] == 16'h0002);
    c_alarm: cover property (@(posedge hclk) alarm_ev[0]);
    c_approach: cover property (@(posedge hclk) arrive[1] && mode[1] == presence_pkg::MODE_APPROACH);
    c_cont_alarm: cover property (@(posedge hclk) alarm_ev[1] && active[1]);

endmodule

`default_nettype wire

// ---- pkg/presence_pkg.sv ----
// Constants, types and register map of the train presence alarm scanner.
// Assumes a single 250 MHz clock and an AHB-Lite register bus.
package presence_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned END_GAP_S = 9;
    localparam int unsigned END_GAP_CYC = END_GAP_S * CLK_MHZ * 1000000;
    localparam int unsigned GAP_W = 32;
    localparam int unsigned VALID_AXLES = 4;
    localparam int unsigned TEST_AXLES = 2;
    localparam int unsigned REARM_AXLES = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CFG0_OFF = 8'h00;
    localparam logic [7:0] CFG1_OFF = 8'h04;
    localparam logic [7:0] STAT0_OFF = 8'h08;
    localparam logic [7:0] STAT1_OFF = 8'h0C;
    localparam logic [7:0] EVENT_OFF = 8'h10;
    localparam logic [7:0] REC0_OFF = 8'h14;
    localparam logic [7:0] REC1_OFF = 8'h18;

    // Config word: [1:0] mode, [7:4] type input 0, +4 per input
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned TYPE_LSB = 4;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Event word bits, per track: base 0 or 8
    localparam int unsigned EV_ARRIVE = 0;
    localparam int unsigned EV_DEPART = 1;
    localparam int unsigned EV_ALARM = 2;
    localparam int unsigned EV_TRACK_STRIDE = 8;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_TRANSDUCER,
        MODE_APPROACH,
        MODE_CONTINUOUS
    } mode_e;

    typedef enum logic [3:0] {
        ALM_NOT_USED,
        ALM_DRAGGING,
        ALM_HIGH_LOAD,
        ALM_WIDE_LOAD,
        ALM_SHIFTED_LOAD,
        ALM_SLIDE_FENCE,
        ALM_SLIP,
        ALM_HIGH_WATER,
        ALM_COLLISION,
        ALM_FIRE,
        ALM_POWER_OFF
    } alarm_type_e;

    typedef enum logic [1:0] {
        CLASS_NONE,
        CLASS_VALID,
        CLASS_TEST
    } class_e;

    // Buffered train record
    typedef struct packed {
        logic [1:0] cls;
        logic [3:0] alarm_seen;
        logic [3:0] stuck;
        logic [15:0] axles;
    } record_s;

    // Raw track inputs
    typedef struct packed {
        logic transducer;
        logic approach_circuit_input;
        logic alarm_input_first;
        logic alarm_input_second;
        logic alarm_input_third;
        logic alarm_input_fourth;
    } track_pins_s;

endpackage

// ---- verif/far_side.sv ----
// Far-side model: wheel transducers, track contact and alarm dry contacts.
// Assumes the bench calls its tasks; a contact reads high while closed.
`timescale 1ns/1ps
`default_nettype none

module far_side (
    input wire logic hclk,
    output var presence_pkg::track_pins_s [1:0] pins
);
    // ----
    // Idle levels
    // ----
    // Contacts rest closed, so an unwired input can never look open
    initial begin
        pins = '0;
        pins[0][3:0] = 4'hF;
        pins[1][3:0] = 4'hF;
    end

    // ----
    // Stimulus tasks
    // ----
    // Pulse period 47 cycles, far below the gap threshold
    task automatic axle(input int t);
        @(posedge hclk);
        pins[t].transducer <= 1'b1;
        repeat (6) @(posedge hclk);
        pins[t].transducer <= 1'b0;
        repeat (40) @(posedge hclk);
    endtask

    task automatic contact(input int t, input int i, input logic v);
        @(posedge hclk);
        pins[t][3-i] <= v;
    endtask

    task automatic approach(input int t, input logic v);
        @(posedge hclk);
        pins[t].approach_circuit_input <= v;
    endtask
endmodule

`default_nettype wire

// ---- verif/train_presence_alarm_scanner_tb.sv ----
// Self-checking bench for the train presence alarm scanner.
// Assumes the far_side model on the pins and a single AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none

module train_presence_alarm_scanner_tb;
    // Short end gap keeps each train to a few hundred cycles
    localparam int unsigned GAP = 200;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    wire hready;
    presence_pkg::track_pins_s [1:0] pins;
    logic [1:0] scanning;
    logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    train_presence_alarm_scanner #(.END_GAP(GAP)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .scanning(scanning)
    );

    far_side i_far (.hclk(hclk), .pins(pins));

    // ----
    // Checking and bus tasks
    // ----
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Holds each phase until hready is seen high; no wait count assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hsize <= 3'b000;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q & m, e);
        check(32'(hresp), 32'h0);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Sampled mid-cycle, clear of the edge that updates it
    task automatic scan_is(input int t, input logic v);
        @(negedge hclk);
        check(32'(scanning[t]), 32'(v));
    endtask

    // Still active well into the gap, gone soon after the threshold
    task automatic depart(input int t);
        wt(100);
        scan_is(t, 1'b1);
        for (int k = 0; k < 150 && scanning[t] !== 1'b0; k++) @(negedge hclk);
        scan_is(t, 1'b0);
    endtask

    task automatic clear_events;
        wr(presence_pkg::EVENT_OFF, 32'hFFFF_FFFF);
        rd(presence_pkg::EVENT_OFF, 32'hFFFF_FFFF, 32'h0);
    endtask

    // ----
    // Timeout
    // ----
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // ----
    // Main sequence
    // ----
    initial begin
        logic [31:0] e;
        wt(12);
        hresetn <= 1'b1;
        for (int k = 0; k < 8; k++) rd(offs[k], 32'hFFFF_FFFF, 32'h0);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h0);
        wr(presence_pkg::CFG0_OFF, 32'h0004_3211);
        rd(presence_pkg::CFG0_OFF, 32'h000F_FFF3, 32'h0004_3211);
        scan_is(0, 1'b0);
        // Approach contact means nothing on a transducer track
        i_far.approach(0, 1'b1);
        wt(6);
        scan_is(0, 1'b0);
        i_far.approach(0, 1'b0);
        // Axle counts 1 to 4; the one-axle pass must leave no record
        for (int n = 1; n <= 4; n++) begin
            i_far.axle(0);
            scan_is(0, 1'b1);
            for (int i = 1; i < n; i++) i_far.axle(0);
            depart(0);
            e = {6'h0, (n < 4) ? presence_pkg::CLASS_TEST : presence_pkg::CLASS_VALID,
                 8'h00, 16'(n)};
            if (n == 1) e = 32'h0;
            rd(presence_pkg::REC0_OFF, 32'h03FF_FFFF, e);
            rd(presence_pkg::EVENT_OFF, (n > 1) ? 32'h3 : 32'h1, (n > 1) ? 32'h3 : 32'h1);
            clear_events();
        end
        // Stuck input before arrival; fire type on a train track
        wr(presence_pkg::CFG0_OFF, 32'h0004_9211);
        i_far.contact(0, 1, 1'b0);
        wt(10);
        i_far.axle(0);
        i_far.contact(0, 2, 1'b0);
        for (int i = 0; i < 3; i++) i_far.axle(0);
        rd(presence_pkg::STAT0_OFF, 32'hFF00_0000, 32'h0200_0000);
        rd(presence_pkg::EVENT_OFF, 32'h4, 32'h0);
        i_far.contact(0, 3, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h4, 32'h4);
        i_far.contact(0, 3, 1'b1);
        i_far.contact(0, 1, 1'b1);
        i_far.contact(0, 2, 1'b1);
        depart(0);
        rd(presence_pkg::REC0_OFF, 32'h03FF_FFFF, 32'h0182_0004);
        clear_events();
        // Dragger alarm, blocked repeat, rearm after exactly three axles
        wr(presence_pkg::CFG0_OFF, 32'h0004_3211);
        i_far.axle(0);
        i_far.axle(0);
        rd(presence_pkg::STAT0_OFF, 32'h0001_FFFF, 32'h0001_0002);
        i_far.contact(0, 0, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h4, 32'h4);
        rd(presence_pkg::STAT0_OFF, 32'h1000_0000, 32'h1000_0000);
        wr(presence_pkg::EVENT_OFF, 32'h4);
        i_far.contact(0, 0, 1'b1);
        i_far.axle(0);
        i_far.contact(0, 0, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h4, 32'h0);
        i_far.contact(0, 0, 1'b1);
        i_far.axle(0);
        i_far.axle(0);
        i_far.contact(0, 0, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h4, 32'h4);
        i_far.contact(0, 0, 1'b1);
        depart(0);
        rd(presence_pkg::REC0_OFF, 32'h03F0_FFFF, 32'h0110_0005);
        clear_events();
        // Approach track, second track only; inputs 2 to 4 unused
        wr(presence_pkg::CFG1_OFF, 32'h0000_0012);
        i_far.approach(1, 1'b1);
        wt(6);
        scan_is(1, 1'b1);
        scan_is(0, 1'b0);
        i_far.contact(1, 1, 1'b0);
        i_far.contact(1, 2, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h0400, 32'h0);
        i_far.contact(1, 0, 1'b0);
        wt(10);
        rd(presence_pkg::EVENT_OFF, 32'h0400, 32'h0400);
        i_far.contact(1, 0, 1'b1);
        i_far.contact(1, 1, 1'b1);
        i_far.contact(1, 2, 1'b1);
        wt(300);
        scan_is(1, 1'b1);
        i_far.approach(1, 1'b0);
        wt(6);
        scan_is(1, 1'b0);
        rd(presence_pkg::REC1_OFF, 32'h03F0_0000, 32'h0110_0000);
        rd(presence_pkg::EVENT_OFF, 32'h0300, 32'h0300);
        clear_events();
        // Continuous scan with auxiliary types, alarm at once
        wr(presence_pkg::CFG1_OFF, 32'h000A_9653);
        wt(6);
        scan_is(1, 1'b1);
        i_far.axle(1);
        rd(presence_pkg::STAT1_OFF, 32'h0001_FFFF, 32'h0001_0001);
        i_far.contact(1, 3, 1'b0);
        wt(6);
        rd(presence_pkg::EVENT_OFF, 32'h0400, 32'h0400);
        i_far.contact(1, 3, 1'b1);
        rd(presence_pkg::REC1_OFF, 32'h03FF_FFFF, 32'h0110_0000);
        wr(presence_pkg::CFG1_OFF, 32'h0);
        wt(6);
        scan_is(1, 1'b0);
        finish_test();
    end
endmodule

`default_nettype wire
